// *** pkg/qld_pkg.sv ***
// constants and types for the front-panel port lamp driver
// assumes a single 20 MHz reference clock shared by the whole block
package qld_pkg;

  // lamp and port geometry
  localparam int CAGES          = 8;
  localparam int PORTS          = 16;
  localparam int LANES          = 4;
  localparam int LAMPS_PER_CAGE = 6;
  localparam int LAMPS          = 48;
  localparam int FANS           = 4;
  localparam int FRAME_BITS     = 64;
  localparam int FIFO_DEPTH     = 8;

  // lamp position inside one cage group
  localparam int LAMP_GRN1 = 0;
  localparam int LAMP_BLU1 = 1;
  localparam int LAMP_BLU2 = 2;
  localparam int LAMP_BLU3 = 3;
  localparam int LAMP_GRN4 = 4;
  localparam int LAMP_BLU4 = 5;

  // serial frame counter
  localparam int         FRAME_CNT_W    = 7;
  localparam logic [6:0] FRAME_CNT_FULL = 7'h40;

  // timing
  localparam int unsigned REF_CLK_HZ      = 20_000_000;
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYCLES = (REF_CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int          DEB_CNT_W       = 18;

  // i2c target
  localparam logic [6:0] I2C_TARGET_ADDR = 7'h2C;
  localparam logic [3:0] I2C_BITS_BYTE   = 4'h8;
  localparam logic [7:0] MODE_RESET      = 8'h00;

  // synchroniser reset levels: idle level of each pin, fan faults in the top bits
  localparam logic [11:0] PIN_IDLE = 12'h078;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'h01,
    I2C_ADDR = 5'h02,
    I2C_AACK = 5'h04,
    I2C_DATA = 5'h08,
    I2C_DACK = 5'h10
  } qld_i2c_state_t;

endpackage

// *** rtl/qld_lamp_driver.sv ***
// front-panel lamp driver: serial status stream to 48 lamps, i2c mode register,
// selection button and management lamps
// assumes all pin inputs are asynchronous to ref_clk; sda is open drain outside
//
// What this block does
// R1: shift serial stream in and drive 48 lamp outputs with port line state
// R2: each cage drives two bicolour edge lamps and two blue middle lamps
// R3: each port is either four 10G lanes or one 40G port
// R4: 10G shows all four lamps; 40G uses only edge lamps 1 and 4
// R5: keep top/bottom selection from the button and drive two indicator lamps
// R6: button acts only with a 10G port; both 40G shows both in green
// R7: both 40G, top: lamp 1 green shows top port, lamps 2 and 3 off
// R8: both 40G, bottom: lamp 4 green shows a 40G port, middle lamps off
// R9: both 10G: lamps 1 to 4 blue show top port lanes in either state
// R10: top 40G, bottom 10G, top selected: lamp 1 green, others off
// R11: top 40G, bottom 10G, bottom selected: lamps 1 to 4 blue, bottom lanes
// R12: top 10G, bottom 40G: top shows blue lanes; bottom shows lamp 4 green
// R13: i2c target holds 8-bit mode registers setting each port 10G or 40G
// R14: heartbeat lamp lights while its active-low drive input is low
// R15: power lamp lit by driving its control high when power is good
// R16: fan lamps show a fault in any fan module
// R17: button is synchronised, debounced, toggles selection once per press
// R18: lamps update only from complete frames held in a holding register
`timescale 1ns/1ps

module qld_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

module qld_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

module qld_lamp_driver
  import qld_pkg::*;
#(
  parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              led_sclk,
  input  wire logic              led_sdata,
  input  wire logic              led_latch,
  output logic                   frame_ready,
  input  wire logic              lamp_freeze,
  input  wire logic              sel_button_n,
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  input  wire logic              heartbeat_drive_n,
  input  wire logic              power_good,
  input  wire logic [FANS-1:0]   fan_fault,
  output logic      [LAMPS-1:0]  lamp_drive,
  output logic                   sel_top_lamp,
  output logic                   sel_bottom_lamp,
  output logic                   heartbeat_lamp_n,
  output logic                   power_good_lamp,
  output logic      [FANS-1:0]   fan_fault_lamp,
  output logic      [PORTS-1:0]  port_mode
);
  localparam int SYNC_W = 8 + FANS;

  logic [SYNC_W-1:0]      sync_vec;
  logic                   sclk_s, sdata_s, latch_s, btn_s, scl_s, sda_s, hb_s, pg_s;
  logic [FANS-1:0]        fan_s;
  logic                   sclk_d_ff, latch_d_ff, scl_d_ff, sda_d_ff;
  logic                   sclk_rise, latch_rise, scl_rise, scl_fall, i2c_start, i2c_stop;
  logic [FRAME_BITS-1:0]  frame_sr_ff;
  logic [FRAME_CNT_W-1:0] frame_cnt_ff;
  logic                   frame_push;
  logic                   fifo_out_valid;
  logic [FRAME_BITS-1:0]  fifo_out_data;
  logic [FRAME_BITS-1:0]  disp_ff;
  logic [DEB_CNT_W-1:0]   deb_cnt_ff;
  logic                   btn_stable_ff;
  logic                   btn_press;
  logic                   any_10g;
  logic                   sel_bot_ff;
  qld_i2c_state_t         i2c_state_ff;
  logic [3:0]             bit_cnt_ff;
  logic [7:0]             i2c_sr_ff;
  logic                   sda_oe_ff;
  logic                   byte_ptr_ff;
  logic                   mode_wr;
  logic [7:0]             mode_lo_ff, mode_hi_ff;
  logic [LAMPS-1:0]       nxt_lamp;
  logic [LAMPS-1:0]       lamp_ff;
  logic                   hb_lamp_n_ff, pg_lamp_ff;
  logic [FANS-1:0]        fan_lamp_ff;

  // two-stage synchronisers for every pin input except lamp_freeze
  // reset to idle pin levels, so no false edge or press follows reset
  qld_sync #(.W(SYNC_W), .RST_VAL(PIN_IDLE)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({fan_fault, power_good, heartbeat_drive_n, sda_in, scl, sel_button_n,
                led_latch, led_sdata, led_sclk}),
    .sync_out (sync_vec)
  );

  assign {fan_s, pg_s, hb_s, sda_s, scl_s, btn_s, latch_s, sdata_s, sclk_s} = sync_vec;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_ff  <= 1'b0;
      latch_d_ff <= 1'b0;
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
    end else begin
      sclk_d_ff  <= sclk_s;
      latch_d_ff <= latch_s;
      scl_d_ff   <= scl_s;
      sda_d_ff   <= sda_s;
    end
  end

  assign sclk_rise  = sclk_s & ~sclk_d_ff;
  assign latch_rise = latch_s & ~latch_d_ff;
  assign scl_rise   = scl_s & ~scl_d_ff;
  assign scl_fall   = ~scl_s & scl_d_ff;
  assign i2c_start  = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign i2c_stop   = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // serial stream into the holding register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_sr_ff  <= '0;
      frame_cnt_ff <= '0;
    end else if (latch_rise) begin
      frame_cnt_ff <= '0;
    end else if (sclk_rise) begin
      frame_sr_ff <= {frame_sr_ff[FRAME_BITS-2:0], sdata_s}; // [R1]
      if (frame_cnt_ff != FRAME_CNT_FULL) begin
        frame_cnt_ff <= frame_cnt_ff + 1'b1;
      end
    end
  end

  // only a frame of full length or longer is queued; the counter saturates, so a longer frame keeps its last 64 bits
  assign frame_push = latch_rise & (frame_cnt_ff == FRAME_CNT_FULL); // [R18]

  qld_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (frame_push),
    .in_ready  (frame_ready),
    .in_data   (frame_sr_ff),
    .out_valid (fifo_out_valid),
    .out_ready (~lamp_freeze),
    .out_data  (fifo_out_data)
  );

  // displayed frame, swapped whole
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_ff <= '0;
    end else if (fifo_out_valid && !lamp_freeze) begin
      disp_ff <= fifo_out_data; // [R18]
    end
  end

  // button debounce, press is a released-to-pressed step
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deb_cnt_ff    <= '0;
      btn_stable_ff <= 1'b1;
    end else if (btn_s == btn_stable_ff) begin
      deb_cnt_ff <= '0;
    end else if (deb_cnt_ff == DEB_CNT_W'(DEBOUNCE_LEN - 1)) begin
      deb_cnt_ff    <= '0;
      btn_stable_ff <= btn_s; // [R17]
    end else begin
      deb_cnt_ff <= deb_cnt_ff + 1'b1;
    end
  end

  assign btn_press = btn_stable_ff & ~btn_s & (deb_cnt_ff == DEB_CNT_W'(DEBOUNCE_LEN - 1));
  assign any_10g   = ~(&port_mode);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_bot_ff <= 1'b0;
    end else if (btn_press && any_10g) begin
      sel_bot_ff <= ~sel_bot_ff; // [R5] [R6] [R17]
    end
  end

  // i2c write-only target
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      i2c_state_ff <= I2C_IDLE;
      bit_cnt_ff   <= '0;
      i2c_sr_ff    <= '0;
      sda_oe_ff    <= 1'b0;
    end else if (i2c_start) begin
      i2c_state_ff <= I2C_ADDR;
      bit_cnt_ff   <= '0;
      sda_oe_ff    <= 1'b0;
    end else if (i2c_stop) begin
      i2c_state_ff <= I2C_IDLE;
      sda_oe_ff    <= 1'b0;
    end else begin
      unique case (i2c_state_ff)
        I2C_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        I2C_ADDR, I2C_DATA: begin
          if (scl_rise && bit_cnt_ff != I2C_BITS_BYTE) begin
            i2c_sr_ff  <= {i2c_sr_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
          end else if (scl_fall && bit_cnt_ff == I2C_BITS_BYTE) begin
            if (i2c_state_ff == I2C_DATA) begin
              i2c_state_ff <= I2C_DACK;
              sda_oe_ff    <= 1'b1;
            end else if (i2c_sr_ff == {I2C_TARGET_ADDR, 1'b0}) begin
              i2c_state_ff <= I2C_AACK;
              sda_oe_ff    <= 1'b1;
            end else begin
              i2c_state_ff <= I2C_IDLE;
            end
          end
        end
        I2C_AACK, I2C_DACK: begin
          if (scl_fall) begin
            i2c_state_ff <= I2C_DATA;
            bit_cnt_ff   <= '0;
            sda_oe_ff    <= 1'b0;
          end
        end
        default: begin
          i2c_state_ff <= I2C_IDLE;
          sda_oe_ff    <= 1'b0;
        end
      endcase
    end
  end

  assign mode_wr = (i2c_state_ff == I2C_DATA) & scl_fall & (bit_cnt_ff == I2C_BITS_BYTE)
                 & ~i2c_start & ~i2c_stop;

  // mode registers, bit set means the port runs as one 40G port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_lo_ff  <= MODE_RESET;
      mode_hi_ff  <= MODE_RESET;
      byte_ptr_ff <= 1'b0;
    end else if (i2c_state_ff == I2C_AACK && scl_fall) begin
      byte_ptr_ff <= 1'b0;
    end else if (mode_wr) begin
      byte_ptr_ff <= ~byte_ptr_ff;
      if (byte_ptr_ff) begin
        mode_hi_ff <= i2c_sr_ff; // [R13]
      end else begin
        mode_lo_ff <= i2c_sr_ff; // [R13]
      end
    end
  end

  assign port_mode = {mode_hi_ff, mode_lo_ff};

  // per-cage lamp decode
  always_comb begin
    logic       top40;
    logic       bot40;
    logic       show_bot;
    logic       show40;
    logic [3:0] lanes;
    int         base;
    top40    = 1'b0;
    bot40    = 1'b0;
    show_bot = 1'b0;
    show40   = 1'b0;
    lanes    = '0;
    base     = 0;
    nxt_lamp = '0;
    for (int c = 0; c < CAGES; c++) begin
      top40    = port_mode[2*c];     // [R3]
      bot40    = port_mode[2*c+1];   // [R3]
      base     = c * LAMPS_PER_CAGE; // [R2]
      show_bot = sel_bot_ff & (top40 ^ bot40); // [R9]
      lanes    = show_bot ? disp_ff[(2*c+1)*LANES +: LANES] : disp_ff[2*c*LANES +: LANES];
      show40   = show_bot ? bot40 : top40;
      if (top40 && bot40) begin
        nxt_lamp[base+LAMP_GRN1] = disp_ff[2*c*LANES];     // [R6] [R7]
        nxt_lamp[base+LAMP_GRN4] = disp_ff[(2*c+1)*LANES]; // [R6] [R8]
      end else if (show40 && show_bot) begin
        nxt_lamp[base+LAMP_GRN4] = lanes[0]; // [R4] [R12]
      end else if (show40) begin
        nxt_lamp[base+LAMP_GRN1] = lanes[0]; // [R4] [R10]
      end else begin
        nxt_lamp[base+LAMP_BLU1] = lanes[0]; // [R4] [R9] [R11] [R12]
        nxt_lamp[base+LAMP_BLU2] = lanes[1];
        nxt_lamp[base+LAMP_BLU3] = lanes[2];
        nxt_lamp[base+LAMP_BLU4] = lanes[3];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lamp_ff <= '0;
    end else begin
      lamp_ff <= nxt_lamp; // [R1]
    end
  end

  // management lamps
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_lamp_n_ff <= 1'b1;
      pg_lamp_ff   <= 1'b0;
      fan_lamp_ff  <= '0;
    end else begin
      hb_lamp_n_ff <= hb_s;  // [R14]
      pg_lamp_ff   <= pg_s;  // [R15]
      fan_lamp_ff  <= fan_s; // [R16]
    end
  end

  assign lamp_drive       = lamp_ff;
  assign sel_top_lamp     = ~sel_bot_ff; // [R5]
  assign sel_bottom_lamp  = sel_bot_ff;  // [R5]
  assign heartbeat_lamp_n = hb_lamp_n_ff;
  assign power_good_lamp  = pg_lamp_ff;
  assign fan_fault_lamp   = fan_lamp_ff;
  assign sda_out          = 1'b0;
  assign sda_oe           = sda_oe_ff;

  // checks, cage 0 stands for all cages
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_full_frame;
    frame_push ##0 !fifo_out_valid ##0 !lamp_freeze ##1 !lamp_freeze;
  endsequence

  sequence s_ignored_press;
    btn_press ##0 (&port_mode);
  endsequence

  a_frame_to_lamps: assert property ( // [R18]
    s_full_frame |-> ##1 disp_ff == $past(frame_sr_ff, 2))
    else $error("complete frame did not reach display");

  a_both40_edges: assert property ( // [R7]
    port_mode[0] && port_mode[1] |=> lamp_drive[LAMP_GRN1] == $past(disp_ff[0])
      && lamp_drive[LAMP_GRN4] == $past(disp_ff[4]))
    else $error("both 40G edge lamps wrong");

  a_forty_middle_off: assert property ( // [R4]
    (port_mode[0] && port_mode[1]) || (port_mode[0] && !sel_bot_ff)
      || (port_mode[1] && sel_bot_ff) |=>
      !lamp_drive[LAMP_BLU2] && !lamp_drive[LAMP_BLU3])
    else $error("middle lamps lit for 40G");

  a_both10_top: assert property ( // [R9]
    !port_mode[0] && !port_mode[1] |=>
      lamp_drive[LAMP_BLU3:LAMP_BLU1] == $past(disp_ff[2:0])
      && lamp_drive[LAMP_BLU4] == $past(disp_ff[3]))
    else $error("both 10G lamps not top lanes");

  a_mixed_top_green: assert property ( // [R10]
    port_mode[0] && !port_mode[1] && !sel_bot_ff |=>
      lamp_drive[LAMP_GRN1] == $past(disp_ff[0]) && lamp_drive[5:1] == 5'h00)
    else $error("top 40G selected shows wrong lamps");

  a_mixed_bot_blue: assert property ( // [R11]
    port_mode[0] && !port_mode[1] && sel_bot_ff |=>
      lamp_drive[LAMP_BLU3:LAMP_BLU1] == $past(disp_ff[6:4]) && !lamp_drive[LAMP_GRN1])
    else $error("bottom 10G lanes not shown");

  a_mixed_bot_green: assert property ( // [R12]
    !port_mode[0] && port_mode[1] && sel_bot_ff |=>
      lamp_drive[LAMP_GRN4] == $past(disp_ff[4]) && lamp_drive[3:0] == 4'h0)
    else $error("bottom 40G selected shows wrong lamps");

  a_press_ignored: assert property ( // [R6]
    s_ignored_press |=> sel_bot_ff == $past(sel_bot_ff) ##1 sel_bottom_lamp == $past(sel_bot_ff, 2))
    else $error("button acted with all ports 40G");

  a_press_toggles: assert property ( // [R17]
    btn_press && any_10g |=> sel_top_lamp == $past(sel_bottom_lamp))
    else $error("press did not toggle selection");

  a_mode_write_ack: assert property ( // [R13]
    mode_wr |=> sda_oe && i2c_state_ff == I2C_DACK)
    else $error("written byte not acknowledged");

  a_heartbeat_follow: assert property ( // [R14]
    $past(rst_n, 3) |-> heartbeat_lamp_n == $past(heartbeat_drive_n, 3))
    else $error("heartbeat lamp does not follow drive");

  a_power_follow: assert property ( // [R15]
    $past(rst_n, 3) |-> power_good_lamp == $past(power_good, 3))
    else $error("power lamp does not follow power good");

endmodule

// *** verif/qld_stream_model.sv ***
// far-side model: serial lamp status stream of the switching chip
// assumes the bench calls send_frame; pins change just after ref_clk rising edges
`timescale 1ns/1ps

module qld_stream_model (
  input  wire logic ref_clk,
  output logic      led_sclk,
  output logic      led_sdata,
  output logic      led_latch
);
  initial begin
    led_sclk  = 1'b0;
    led_sdata = 1'b0;
    led_latch = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // msb first; bit clock stands low between frames; data inverted once released
  task automatic send_frame(input logic [63:0] f, input int nbits);
    for (int i = nbits - 1; i >= 0; i--) begin
      @(posedge ref_clk) led_sdata <= f[i];
      wt(2);
      @(posedge ref_clk) led_sclk <= 1'b1;
      wt(2);
      @(posedge ref_clk) led_sclk <= 1'b0;
    end
    @(posedge ref_clk) led_sdata <= ~led_sdata;
    wt(2);
    @(posedge ref_clk) led_latch <= 1'b1;
    wt(3);
    @(posedge ref_clk) led_latch <= 1'b0;
  endtask
endmodule

// *** verif/qld_lamp_driver_bench.sv ***
// testbench: lamp driver with stream model, i2c host tasks and button tasks
// assumes qld_pkg and the stream model are compiled first
`timescale 1ns/1ps

module qld_lamp_driver_bench
  import qld_pkg::*;
;
  localparam int DEB = 8;

  logic             ref_clk = 1'b0;
  logic             rst_n, lamp_freeze, sel_button_n, scl, sda_drv, sda_line;
  logic             heartbeat_drive_n, power_good, heartbeat_lamp_n, power_good_lamp;
  logic             led_sclk, led_sdata, led_latch, frame_ready, sda_out, sda_oe;
  logic             sel_top_lamp, sel_bottom_lamp;
  logic [FANS-1:0]  fan_fault, fan_fault_lamp;
  logic [LAMPS-1:0] lamp_drive;
  logic [PORTS-1:0] port_mode, md;
  logic [63:0]      fr;
  int               n_errors, num_checks, cycles;

  // open-drain data line: high unless the host or the target pulls it low
  assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);

  always #25 ref_clk = ~ref_clk;

  qld_stream_model stream (
    .ref_clk   (ref_clk),
    .led_sclk  (led_sclk),
    .led_sdata (led_sdata),
    .led_latch (led_latch)
  );

  qld_lamp_driver #(.DEBOUNCE_LEN(DEB)) uut (
    .ref_clk           (ref_clk),
    .rst_n             (rst_n),
    .led_sclk          (led_sclk),
    .led_sdata         (led_sdata),
    .led_latch         (led_latch),
    .frame_ready       (frame_ready),
    .lamp_freeze       (lamp_freeze),
    .sel_button_n      (sel_button_n),
    .scl               (scl),
    .sda_in            (sda_line),
    .sda_out           (sda_out),
    .sda_oe            (sda_oe),
    .heartbeat_drive_n (heartbeat_drive_n),
    .power_good        (power_good),
    .fan_fault         (fan_fault),
    .lamp_drive        (lamp_drive),
    .sel_top_lamp      (sel_top_lamp),
    .sel_bottom_lamp   (sel_bottom_lamp),
    .heartbeat_lamp_n  (heartbeat_lamp_n),
    .power_good_lamp   (power_good_lamp),
    .fan_fault_lamp    (fan_fault_lamp),
    .port_mode         (port_mode)
  );

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // expected lamps per cage from frame, port modes and selection
  function automatic logic [47:0] exp_lamps(logic [63:0] f, logic [15:0] m, logic bot);
    logic [47:0] r;
    int          t;
    int          b;
    int          p;
    r = '0;
    for (int c = 0; c < CAGES; c++) begin
      t = 2 * c;
      b = t + 1;
      p = m[t] ? b : t;
      if (m[t] && m[b]) begin
        r[6*c]   = f[4*t];
        r[6*c+4] = f[4*b];
      end else if (m[t] && !bot)
        r[6*c] = f[4*t];
      else if (m[b] && bot)
        r[6*c+4] = f[4*b];
      else begin
        r[6*c+1] = f[4*p];
        r[6*c+2] = f[4*p+1];
        r[6*c+3] = f[4*p+2];
        r[6*c+5] = f[4*p+3];
      end
    end
    return r;
  endfunction

  task automatic look(input string nm, input logic bot);
    wt(16);
    check(nm, lamp_drive, exp_lamps(fr, md, bot));
  endtask

  task automatic i2c_bit(input logic d, output logic seen);
    wt(3);
    @(posedge ref_clk) sda_drv <= d;
    wt(3);
    @(posedge ref_clk) scl <= 1'b1;
    wt(7);
    seen = sda_line;
    @(posedge ref_clk) scl <= 1'b0;
  endtask

  task automatic i2c_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      i2c_bit(d[i], s);
    i2c_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic i2c_write(input logic [6:0] a, input logic [15:0] d, input logic exp_ack);
    logic k;
    @(posedge ref_clk) sda_drv <= 1'b0;
    wt(8);
    @(posedge ref_clk) scl <= 1'b0;
    i2c_byte({a, 1'b0}, k);
    check("i2c address ack", k, exp_ack);
    if (k) begin
      i2c_byte(d[7:0], k);
      check("i2c data ack", k, 1'b1);
      i2c_byte(d[15:8], k);
      check("i2c data ack", k, 1'b1);
    end
    wt(3);
    @(posedge ref_clk) sda_drv <= 1'b0;
    wt(3);
    @(posedge ref_clk) scl <= 1'b1;
    wt(7);
    @(posedge ref_clk) sda_drv <= 1'b1;
    wt(8);
  endtask

  task automatic press(input int low);
    @(posedge ref_clk) sel_button_n <= 1'b0;
    wt(low);
    @(posedge ref_clk) sel_button_n <= 1'b1;
    wt(DEB + 8);
  endtask

  task automatic t_reset();
    check("lamps", lamp_drive, 0);
    check("selection lamps", {sel_top_lamp, sel_bottom_lamp}, 2'b10);
    check("misc lamps", {heartbeat_lamp_n, power_good_lamp, fan_fault_lamp}, 6'h20);
    check("port mode", port_mode, 0);
    check("ready and sda", {frame_ready, sda_oe, sda_out}, 3'b100);
  endtask

  task automatic t_misc();
    @(posedge ref_clk) heartbeat_drive_n <= 1'b0;
    power_good <= 1'b1;
    fan_fault  <= 4'h5;
    wt(6);
    check("heartbeat lamp", heartbeat_lamp_n, 1'b0);
    check("power lamp", power_good_lamp, 1'b1);
    check("fan lamps", fan_fault_lamp, 4'h5);
    @(posedge ref_clk) heartbeat_drive_n <= 1'b1;
    power_good <= 1'b0;
    fan_fault  <= 4'hA;
    wt(6);
    check("misc lamps", {heartbeat_lamp_n, power_good_lamp, fan_fault_lamp}, 6'h2A);
  endtask

  task automatic t_i2c();
    md = 16'hD8D8;
    i2c_write(7'h2C, md, 1'b1);
    wt(4);
    check("port mode", port_mode, md);
    i2c_write(7'h2D, 16'h0000, 1'b0);
    check("port mode kept", port_mode, md);
  endtask

  task automatic t_decode();
    fr = 64'hA5C3_96F0_0F69_3C5A;
    stream.send_frame(fr, 64);
    look("lamps top", 1'b0);
    press(DEB + 8);
    check("selection lamps", {sel_top_lamp, sel_bottom_lamp}, 2'b01);
    look("lamps bottom", 1'b1);
    press(4);
    check("bounce ignored", {sel_top_lamp, sel_bottom_lamp}, 2'b01);
    press(DEB + 8);
    check("selection lamps", {sel_top_lamp, sel_bottom_lamp}, 2'b10);
    stream.send_frame(~fr, 63);
    look("short frame dropped", 1'b0);
  endtask

  task automatic t_fifo();
    @(posedge ref_clk) lamp_freeze <= 1'b1;
    for (int i = 1; i <= 9; i++) begin
      stream.send_frame(fr ^ {16{4'(i)}}, 64);
      wt(6);
      check("frame ready", frame_ready, i < 8);
    end
    check("frozen lamps", lamp_drive, exp_lamps(fr, md, 1'b0));
    @(posedge ref_clk) lamp_freeze <= 1'b0;
    fr = fr ^ {16{4'h8}};
    look("drained lamps", 1'b0);
  endtask

  // cage 0 walks through both mixed layouts before all ports go 40G
  task automatic t_all40();
    md = 16'hD8D9;
    i2c_write(7'h2C, md, 1'b1);
    look("top 40G lamps", 1'b0);
    press(DEB + 8);
    check("selection lamps", {sel_top_lamp, sel_bottom_lamp}, 2'b01);
    look("bottom 10G lamps", 1'b1);
    md = 16'hD8DA;
    i2c_write(7'h2C, md, 1'b1);
    look("bottom 40G lamps", 1'b1);
    md = 16'hFFFF;
    i2c_write(7'h2C, md, 1'b1);
    look("all 40G lamps", 1'b1);
    press(DEB + 8);
    check("button ignored", {sel_top_lamp, sel_bottom_lamp}, 2'b01);
  endtask

  initial begin
    rst_n             = 1'b0;
    lamp_freeze       = 1'b0;
    sel_button_n      = 1'b1;
    scl               = 1'b1;
    sda_drv           = 1'b1;
    heartbeat_drive_n = 1'b1;
    power_good        = 1'b0;
    fan_fault         = '0;
    n_errors          = 0;
    num_checks        = 0;
    cycles            = 0;
    fr                = '0;
    md                = '0;
    wt(5);
    t_reset();
    @(posedge ref_clk) rst_n <= 1'b1;
    wt(3);
    t_reset();
    t_misc();
    t_i2c();
    t_decode();
    t_fifo();
    t_all40();
    end_sim();
  end
endmodule
